// ---- core/hpc_pin_sync.sv ----
// three-flop pin synchroniser, value changes once flops two and three agree
`timescale 1ns/1ns
`default_nettype none
module hpc_pin_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // pins in, clean levels out
   input wire logic [W-1:0] i_pin,
   output logic [W-1:0] o_level
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] next_level;

   // per-bit agreement filter; s1 feeds s2 only
   always_comb
   begin
      for (int b = 0; b < int'(W); b++)
      begin
         next_level[b] = (s2[b] == s3[b]) ? s3[b] : o_level[b];
      end
   end

   // synchroniser chain and filtered level
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_resetn)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         o_level <= '0;
      end
      else
      begin
         s1 <= i_pin;
         s2 <= s1;
         s3 <= s2;
         o_level <= next_level;
      end
   end

endmodule
`default_nettype wire

// ---- core/hpc_pkg.sv ----
// shared constants and types for the hub port control block
package hpc_pkg;

   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int unsigned NCH = 8;
   localparam int unsigned DELAY_W = 16;
   localparam int unsigned SYNC_W = 19;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned MS_CYCLES = 100_000; // one ms of a 10 ns clock

   // ------------------------------------------------------------
   // bulk port map field positions
   // ------------------------------------------------------------
   localparam int unsigned MAP_HS_POS = 0;
   localparam int unsigned MAP_PWR_POS = 1;
   localparam int unsigned MAP_SS_POS = 16;

   // ------------------------------------------------------------
   // codes
   // ------------------------------------------------------------
   localparam logic [7:0] UP_SEL_FIRST = 8'h00;
   localparam logic [7:0] UP_SEL_SECOND = 8'h01;
   localparam logic [7:0] UP_SEL_AUTO = 8'h02;
   localparam logic [7:0] UP_SEL_OFF = 8'hFF;
   localparam logic STANDARD_PORT_MODE = 1'b0;
   localparam logic CHARGING_PORT_MODE = 1'b1;
   localparam logic [1:0] ADV_STANDARD = 2'h0;
   localparam logic [1:0] ADV_CHARGING = 2'h1;
   localparam logic [1:0] ADV_DEDICATED = 2'h2;
   localparam logic [1:0] SPEED_NONE = 2'h0;
   localparam logic [1:0] SPEED_HI = 2'h1;
   localparam logic [1:0] SPEED_SUPER = 2'h2;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [31:0] ILIM_RESET_UA = 32'h003E_7C18;
   localparam logic [DELAY_W-1:0] DELAY_RESET_MS = 16'h0000;
   localparam logic [1:0] BOOST_RESET = 2'h0;
   localparam logic [7:0] UP_SEL_RESET = UP_SEL_AUTO;
   localparam logic MODE_RESET = CHARGING_PORT_MODE;

   // ------------------------------------------------------------
   // command set
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      CMD_PORT_EN, CMD_PORT_DIS, CMD_DATA_EN, CMD_DATA_DIS,
      CMD_HS_EN, CMD_HS_DIS, CMD_SS_EN, CMD_SS_DIS,
      CMD_PWR_EN, CMD_PWR_DIS, CMD_GET_VOLT, CMD_GET_CURR,
      CMD_GET_LIMIT, CMD_SET_LIMIT, CMD_SET_MODE, CMD_GET_MODE,
      CMD_GET_SPEED, CMD_SET_DELAY, CMD_GET_DELAY,
      CMD_SET_DN_BOOST, CMD_GET_DN_BOOST,
      CMD_SET_UP_BOOST, CMD_GET_UP_BOOST,
      CMD_SET_UP_SEL, CMD_GET_UP_SEL,
      CMD_SET_MAP, CMD_GET_MAP, CMD_SAVE, CMD_REBOOT
   } hpc_cmd_e;

endpackage

// ---- core/hpc_port_ctrl.sv ----
// eight-channel hub port control and status core
//
// Overview of operation
// - port command switches high-speed, superspeed, power together
// - data command switches both data paths only
// - high-speed command touches only high-speed path
// - superspeed command touches only superspeed path
// - power command touches only power output
// - read back port voltage and current
// - per-channel current limit, writable and readable
// - speed status: 0 none, 1 hi, 2 super
// - per-channel charging mode 0 standard, 1 charging
// - standard advertises 500mA, charging up to 5A
// - charging mode without host becomes dedicated charger
// - programmable ms delay between ports 0 to 7
// - stagger runs at power-on and new host connection
// - boost codes 0..3 give 0/4/8/12 percent hi-speed
// - boost applies after save and reboot; reset clears
// - separate upstream and downstream boost settings
// - upstream codes 0, 1, 2 auto, 255 off
// - auto picks first upstream when it sees power
// - upstream selection defaults to auto
// - cabled control port takes commands exclusively
// - 32-bit map reads or writes all enables
// - map bit 2n hi-speed, 2n+1 power
// - map bit 16+2n superspeed, odd upper bits reserved
// - hard reset restores factory defaults
`timescale 1ns/1ns
`default_nettype none
module hpc_port_ctrl
   import hpc_pkg::*;
#(
   parameter int unsigned MS_CYCLES_P = hpc_pkg::MS_CYCLES
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // commands from the dedicated control port
   input wire logic i_ctl_cmd_valid,
   input wire hpc_pkg::hpc_cmd_e i_ctl_cmd_op,
   input wire logic [2:0] i_ctl_cmd_chan,
   input wire logic [31:0] i_ctl_cmd_data,
   // commands from the selected upstream port
   input wire logic i_up_cmd_valid,
   input wire hpc_pkg::hpc_cmd_e i_up_cmd_op,
   input wire logic [2:0] i_up_cmd_chan,
   input wire logic [31:0] i_up_cmd_data,
   // command answer
   output logic o_rsp_valid,
   output logic o_rsp_from_ctl,
   output logic [31:0] o_rsp_data,
   // connector and link pins
   input wire logic i_ctl_cable,
   input wire logic i_up0_vbus,
   input wire logic i_up1_vbus,
   input wire logic [hpc_pkg::NCH-1:0] i_link_hs,
   input wire logic [hpc_pkg::NCH-1:0] i_link_ss,
   // measurements from the converter logic
   input wire logic [hpc_pkg::NCH-1:0][31:0] i_meas_uv,
   input wire logic [hpc_pkg::NCH-1:0][31:0] i_meas_ua,
   // per-channel switches and charger advertisement
   output logic [hpc_pkg::NCH-1:0] o_hs_en,
   output logic [hpc_pkg::NCH-1:0] o_ss_en,
   output logic [hpc_pkg::NCH-1:0] o_pwr_en,
   output logic [hpc_pkg::NCH-1:0][1:0] o_adv,
   output logic [hpc_pkg::NCH-1:0][31:0] o_ilim_ua,
   // upstream routing and drive
   output logic o_up0_conn,
   output logic o_up1_conn,
   output logic o_ctl_port_active,
   output logic [1:0] o_boost_up,
   output logic [1:0] o_boost_dn
);

   // ------------------------------------------------------------
   // pin synchronisation
   // ------------------------------------------------------------
   logic [SYNC_W-1:0] pins;
   logic cable, vbus0, vbus1;
   logic [NCH-1:0] lnk_hs, lnk_ss;

   hpc_pin_sync #(.W(SYNC_W)) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_pin({i_link_ss, i_link_hs, i_up1_vbus, i_up0_vbus, i_ctl_cable}),
      .o_level(pins)
   );
   assign cable = pins[0];
   assign vbus0 = pins[1];
   assign vbus1 = pins[2];
   assign lnk_hs = pins[3 +: NCH];
   assign lnk_ss = pins[3 + NCH +: NCH];

   // ------------------------------------------------------------
   // configuration state
   // ------------------------------------------------------------
   logic [NCH-1:0] hs_en, ss_en, pwr_en, mode;
   logic [NCH-1:0][31:0] ilim;
   logic [DELAY_W-1:0] delay_ms;
   logic [1:0] bst_up_p, bst_dn_p, bst_up_s, bst_dn_s;
   logic [7:0] up_sel;
   logic [NCH-1:0] next_hs_en, next_ss_en, next_pwr_en, next_mode;
   logic [NCH-1:0][31:0] next_ilim;
   logic [DELAY_W-1:0] next_delay_ms;
   logic [1:0] next_bst_up_p, next_bst_dn_p, next_bst_up_s, next_bst_dn_s;
   logic [7:0] next_up_sel;
   logic next_rsp_valid, next_rsp_from_ctl;
   logic [31:0] next_rsp_data;
   logic reboot;

   // command source and fields after arbitration
   logic take;
   hpc_cmd_e op;
   logic [2:0] ch;
   logic [31:0] dat;
   logic [31:0] map_rd;
   logic [1:0] speed;
   logic up0_c, up1_c, host;

   // routing of the upstream connection
   always_comb
   begin
      up0_c = 1'b0;
      up1_c = 1'b0;
      unique case (up_sel)
         UP_SEL_FIRST: up0_c = 1'b1;
         UP_SEL_SECOND: up1_c = 1'b1;
         UP_SEL_AUTO: {up0_c, up1_c} = {vbus0, !vbus0};
         default: up0_c = 1'b0;
      endcase
      host = (up0_c && vbus0) || (up1_c && vbus1);
   end

   // a cabled control port owns all control
   always_comb
   begin
      take = cable ? i_ctl_cmd_valid : (i_up_cmd_valid && host);
      op = cable ? i_ctl_cmd_op : i_up_cmd_op;
      ch = cable ? i_ctl_cmd_chan : i_up_cmd_chan;
      dat = cable ? i_ctl_cmd_data : i_up_cmd_data;
   end

   // bulk map view of the same enable flops
   always_comb
   begin
      map_rd = '0;
      for (int n = 0; n < int'(NCH); n++)
      begin
         map_rd[MAP_HS_POS + 2*n] = hs_en[n];
         map_rd[MAP_PWR_POS + 2*n] = pwr_en[n];
         map_rd[MAP_SS_POS + 2*n] = ss_en[n];
      end
      if (lnk_ss[ch])
         speed = SPEED_SUPER;
      else if (lnk_hs[ch])
         speed = SPEED_HI;
      else
         speed = SPEED_NONE;
   end

   // command decode: every accepted command answers one cycle later
   always_comb
   begin
      {next_hs_en, next_ss_en, next_pwr_en, next_mode} =
         {hs_en, ss_en, pwr_en, mode};
      {next_ilim, next_delay_ms, next_up_sel} = {ilim, delay_ms, up_sel};
      {next_bst_up_p, next_bst_dn_p, next_bst_up_s, next_bst_dn_s} =
         {bst_up_p, bst_dn_p, bst_up_s, bst_dn_s};
      next_rsp_valid = take;
      next_rsp_from_ctl = cable;
      next_rsp_data = '0;
      reboot = 1'b0;
      if (take)
      begin
         unique case (op)
            CMD_PORT_EN, CMD_PORT_DIS:
               {next_hs_en[ch], next_ss_en[ch], next_pwr_en[ch]} =
                  {3{op == CMD_PORT_EN}};
            CMD_DATA_EN, CMD_DATA_DIS:
               {next_hs_en[ch], next_ss_en[ch]} =
                  {2{op == CMD_DATA_EN}};
            CMD_HS_EN, CMD_HS_DIS: next_hs_en[ch] = (op == CMD_HS_EN);
            CMD_SS_EN, CMD_SS_DIS: next_ss_en[ch] = (op == CMD_SS_EN);
            CMD_PWR_EN, CMD_PWR_DIS:
               next_pwr_en[ch] = (op == CMD_PWR_EN);
            CMD_GET_VOLT: next_rsp_data = i_meas_uv[ch];
            CMD_GET_CURR: next_rsp_data = i_meas_ua[ch];
            CMD_GET_LIMIT: next_rsp_data = ilim[ch];
            CMD_SET_LIMIT: next_ilim[ch] = dat;
            CMD_SET_MODE: next_mode[ch] = dat[0];
            CMD_GET_MODE: next_rsp_data = {31'h0000_0000, mode[ch]};
            CMD_GET_SPEED: next_rsp_data = {30'h0000_0000, speed};
            CMD_SET_DELAY: next_delay_ms = dat[DELAY_W-1:0];
            CMD_GET_DELAY: next_rsp_data = {16'h0000, delay_ms};
            CMD_SET_DN_BOOST: next_bst_dn_p = dat[1:0];
            CMD_GET_DN_BOOST: next_rsp_data = {30'h0000_0000, bst_dn_p};
            CMD_SET_UP_BOOST: next_bst_up_p = dat[1:0];
            CMD_GET_UP_BOOST: next_rsp_data = {30'h0000_0000, bst_up_p};
            CMD_SET_UP_SEL:
            begin
               // unknown selection codes leave the routing alone
               if (dat[7:0] == UP_SEL_FIRST || dat[7:0] == UP_SEL_SECOND ||
                   dat[7:0] == UP_SEL_AUTO || dat[7:0] == UP_SEL_OFF)
                  next_up_sel = dat[7:0];
            end
            CMD_GET_UP_SEL: next_rsp_data = {24'h00_0000, up_sel};
            CMD_SET_MAP:
            begin
               for (int n = 0; n < int'(NCH); n++)
               begin
                  next_hs_en[n] = dat[MAP_HS_POS + 2*n];
                  next_pwr_en[n] = dat[MAP_PWR_POS + 2*n];
                  next_ss_en[n] = dat[MAP_SS_POS + 2*n];
               end
            end
            CMD_GET_MAP: next_rsp_data = map_rd;
            CMD_SAVE:
               {next_bst_up_s, next_bst_dn_s} = {bst_up_p, bst_dn_p};
            CMD_REBOOT: reboot = 1'b1;
            default: next_rsp_data = '0;
         endcase
      end
   end

   // configuration registers; hard reset restores factory values
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_resetn)
      begin
         {hs_en, ss_en, pwr_en} <= '1;
         mode <= {NCH{MODE_RESET}};
         ilim <= {NCH{ILIM_RESET_UA}};
         delay_ms <= DELAY_RESET_MS;
         {bst_up_p, bst_dn_p} <= {2{BOOST_RESET}};
         {bst_up_s, bst_dn_s} <= {2{BOOST_RESET}};
         up_sel <= UP_SEL_RESET;
         {o_rsp_valid, o_rsp_from_ctl, o_rsp_data} <= '0;
      end
      else
      begin
         {hs_en, ss_en, pwr_en, mode} <=
            {next_hs_en, next_ss_en, next_pwr_en, next_mode};
         {ilim, delay_ms, up_sel} <= {next_ilim, next_delay_ms, next_up_sel};
         {bst_up_p, bst_dn_p, bst_up_s, bst_dn_s} <=
            {next_bst_up_p, next_bst_dn_p, next_bst_up_s, next_bst_dn_s};
         {o_rsp_valid, o_rsp_from_ctl, o_rsp_data} <=
            {next_rsp_valid, next_rsp_from_ctl, next_rsp_data};
      end
   end

   // ------------------------------------------------------------
   // staggered port release
   // ------------------------------------------------------------
   logic [3:0] stg_idx, next_stg_idx;
   logic [31:0] ms_cnt, next_ms_cnt;
   logic [DELAY_W-1:0] elapsed, next_elapsed;
   logic host_q, next_host_q;
   logic [1:0] next_boost_up, next_boost_dn;

   // each later port opens delay_ms after the last; divider restarts per step
   always_comb
   begin
      next_stg_idx = stg_idx;
      next_ms_cnt = ms_cnt;
      next_elapsed = elapsed;
      next_host_q = host;
      {next_boost_up, next_boost_dn} = {o_boost_up, o_boost_dn};
      if (reboot || (host && !host_q))
      begin
         next_stg_idx = 4'h1;
         {next_ms_cnt, next_elapsed} = '0;
         if (reboot)
            {next_boost_up, next_boost_dn} = {bst_up_s, bst_dn_s};
      end
      else if (stg_idx < 4'(NCH))
      begin
         if (elapsed >= delay_ms)
         begin
            next_stg_idx = stg_idx + 4'h1;
            {next_ms_cnt, next_elapsed} = '0;
         end
         else if (ms_cnt == 32'(MS_CYCLES_P - 1))
         begin
            next_ms_cnt = '0;
            next_elapsed = elapsed + 16'h0001;
         end
         else
            next_ms_cnt = ms_cnt + 32'h0000_0001;
      end
   end

   // stagger and active boost registers; power-on starts a sequence
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_resetn)
      begin
         stg_idx <= 4'h1;
         {ms_cnt, elapsed, host_q} <= '0;
         {o_boost_up, o_boost_dn} <= {2{BOOST_RESET}};
      end
      else
      begin
         stg_idx <= next_stg_idx;
         {ms_cnt, elapsed, host_q} <= {next_ms_cnt, next_elapsed, next_host_q};
         {o_boost_up, o_boost_dn} <= {next_boost_up, next_boost_dn};
      end
   end

   // ------------------------------------------------------------
   // per-channel outputs
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_ch
         logic rel;
         logic [1:0] next_adv;
         assign rel = (4'(g) < stg_idx);

         // charging without a host falls back to a dedicated charger
         always_comb
         begin
            if (mode[g] == STANDARD_PORT_MODE)
               next_adv = ADV_STANDARD;
            else if (host)
               next_adv = ADV_CHARGING;
            else
               next_adv = ADV_DEDICATED;
         end

         always_ff @(posedge i_sys_clk)
         begin
            if (!i_resetn)
            begin
               {o_hs_en[g], o_ss_en[g], o_pwr_en[g]} <= '0;
               o_adv[g] <= ADV_STANDARD;
               o_ilim_ua[g] <= ILIM_RESET_UA;
            end
            else
            begin
               o_hs_en[g] <= hs_en[g] && rel;
               o_ss_en[g] <= ss_en[g] && rel;
               o_pwr_en[g] <= pwr_en[g] && rel;
               o_adv[g] <= next_adv;
               o_ilim_ua[g] <= ilim[g];
            end
         end
      end
   endgenerate

   // upstream routing outputs
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_resetn)
      begin
         {o_up0_conn, o_up1_conn, o_ctl_port_active} <= '0;
      end
      else
      begin
         o_up0_conn <= up0_c;
         o_up1_conn <= up1_c;
         o_ctl_port_active <= cable;
      end
   end

endmodule
`default_nettype wire

// ---- test/hpc_host_model.sv ----
// host software model: issues one command at a time, catches the answer
`timescale 1ns/1ns
`default_nettype none
module hpc_host_model (
   // clock
   input wire logic i_sys_clk,
   // command out, shared fields
   output logic o_ctl_valid,
   output logic o_up_valid,
   output hpc_pkg::hpc_cmd_e o_op,
   output logic [2:0] o_chan,
   output logic [31:0] o_data,
   // answer in
   input wire logic i_rsp_valid,
   input wire logic [31:0] i_rsp_data
);
   import hpc_pkg::*;
   logic got;
   logic [31:0] rsp;
   // idle values at time zero
   initial
   begin
      {o_ctl_valid, o_up_valid, o_chan, o_data} = '0;
      o_op = CMD_GET_MAP;
   end
   // one-cycle strobe; answer stands one cycle
   task automatic send(input hpc_cmd_e op, input logic [2:0] ch,
      input logic [31:0] d, input logic ctl);
      @(posedge i_sys_clk);
      o_ctl_valid <= ctl;
      o_up_valid <= !ctl;
      o_op <= op;
      o_chan <= ch;
      o_data <= d;
      @(posedge i_sys_clk);
      o_ctl_valid <= 1'b0;
      o_up_valid <= 1'b0;
      o_data <= ~d; // released data must not look valid
      #1;
      got = i_rsp_valid;
      rsp = i_rsp_data;
   endtask
endmodule
`default_nettype wire

// ---- test/hpc_port_ctrl_chk.sv ----
// concurrent checks on the hub port control ports
`timescale 1ns/1ns
`default_nettype none
module hpc_port_ctrl_chk (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // command inputs
   input wire logic i_ctl_cmd_valid,
   input wire hpc_pkg::hpc_cmd_e i_ctl_cmd_op,
   input wire logic [2:0] i_ctl_cmd_chan,
   input wire logic [31:0] i_ctl_cmd_data,
   input wire logic i_up_cmd_valid,
   input wire hpc_pkg::hpc_cmd_e i_up_cmd_op,
   // design outputs
   input wire logic o_rsp_valid,
   input wire logic o_rsp_from_ctl,
   input wire logic [hpc_pkg::NCH-1:0] o_hs_en,
   input wire logic [hpc_pkg::NCH-1:0] o_ss_en,
   input wire logic [hpc_pkg::NCH-1:0] o_pwr_en,
   input wire logic [hpc_pkg::NCH-1:0][31:0] o_ilim_ua,
   input wire logic o_ctl_port_active,
   input wire logic [1:0] o_boost_dn
);
   import hpc_pkg::*;
   logic tk;
   logic rb;
   logic [2:0] c1;
   logic [2:0] c2;
   // ctl command taken; bench holds cable steady
   assign tk = i_ctl_cmd_valid && o_ctl_port_active;
   assign rb = (i_ctl_cmd_valid && i_ctl_cmd_op == CMD_REBOOT) ||
      (i_up_cmd_valid && i_up_cmd_op == CMD_REBOOT);
   // channel aligned with outputs
   always_ff @(posedge i_sys_clk)
   begin
      c1 <= i_ctl_cmd_chan;
      c2 <= c1;
   end
   ilim_reset_a: assert property (@(posedge i_sys_clk)
      !i_resetn |=> o_ilim_ua == {NCH{ILIM_RESET_UA}})
      else $error("limit not at reset value");
   port_dis_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) tk && i_ctl_cmd_op == CMD_PORT_DIS
      |-> ##2 !o_hs_en[c2] && !o_ss_en[c2] && !o_pwr_en[c2])
      else $error("port disable left a line on");
   data_dis_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) tk && i_ctl_cmd_op == CMD_DATA_DIS
      |-> ##2 !o_hs_en[c2] && !o_ss_en[c2] && $past(o_pwr_en, 2) == o_pwr_en)
      else $error("data disable wrong");
   hs_dis_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) tk && i_ctl_cmd_op == CMD_HS_DIS
      |-> ##2 !o_hs_en[c2] && $past(o_ss_en, 2) == o_ss_en)
      else $error("hs disable wrong");
   ss_dis_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) tk && i_ctl_cmd_op == CMD_SS_DIS
      |-> ##2 !o_ss_en[c2] && $past(o_hs_en, 2) == o_hs_en)
      else $error("ss disable wrong");
   pwr_dis_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) tk && i_ctl_cmd_op == CMD_PWR_DIS
      |-> ##2 !o_pwr_en[c2] && $past(o_hs_en, 2) == o_hs_en)
      else $error("power disable wrong");
   ctl_answer_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) tk |=> o_rsp_valid && o_rsp_from_ctl)
      else $error("control command not answered");
   up_refused_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) o_ctl_port_active && i_up_cmd_valid
      |=> !(o_rsp_valid && !o_rsp_from_ctl))
      else $error("upstream command taken with cable");
   limit_set_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) tk && i_ctl_cmd_op == CMD_SET_LIMIT
      |-> ##2 o_ilim_ua[c2] == $past(i_ctl_cmd_data, 2))
      else $error("limit not applied");
   boost_hold_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) $changed(o_boost_dn)
      |-> $past(rb) || $past(rb, 2))
      else $error("boost changed without reboot");
endmodule
bind hpc_port_ctrl hpc_port_ctrl_chk u_chk (
   .i_sys_clk, .i_resetn, .i_ctl_cmd_valid, .i_ctl_cmd_op, .i_ctl_cmd_chan,
   .i_ctl_cmd_data, .i_up_cmd_valid, .i_up_cmd_op, .o_rsp_valid,
   .o_rsp_from_ctl, .o_hs_en, .o_ss_en, .o_pwr_en, .o_ilim_ua,
   .o_ctl_port_active, .o_boost_dn);
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench for the hub port control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import hpc_pkg::*;
   logic clk, rstn, cable, v0, v1, src, cv, uv, rv, rc, u0, u1, ca;
   logic [NCH-1:0] lhs, lss, ehs, ess, epw, hse, sse, pwe;
   logic [NCH-1:0][31:0] muv, mua, ilim;
   logic [NCH-1:0][1:0] adv;
   hpc_cmd_e op;
   logic [2:0] ch;
   logic [31:0] dat, rd, dr;
   logic [31:0] lim[8];
   logic [1:0] bu, bd;
   int n_fail, check_count, i, c, k, md[8], t[8];
   int codes[4] = '{0, 1, 2, 255};
   hpc_port_ctrl #(.MS_CYCLES_P(10)) dut (.i_sys_clk(clk), .i_resetn(rstn),
      .i_ctl_cmd_valid(cv), .i_ctl_cmd_op(op), .i_ctl_cmd_chan(ch),
      .i_ctl_cmd_data(dat), .i_up_cmd_valid(uv), .i_up_cmd_op(op),
      .i_up_cmd_chan(ch), .i_up_cmd_data(dat), .o_rsp_valid(rv),
      .o_rsp_from_ctl(rc), .o_rsp_data(rd), .i_ctl_cable(cable),
      .i_up0_vbus(v0), .i_up1_vbus(v1), .i_link_hs(lhs), .i_link_ss(lss),
      .i_meas_uv(muv), .i_meas_ua(mua), .o_hs_en(hse), .o_ss_en(sse),
      .o_pwr_en(pwe), .o_adv(adv), .o_ilim_ua(ilim), .o_up0_conn(u0),
      .o_up1_conn(u1), .o_ctl_port_active(ca), .o_boost_up(bu),
      .o_boost_dn(bd));
   hpc_host_model host (.i_sys_clk(clk), .o_ctl_valid(cv), .o_up_valid(uv),
      .o_op(op), .o_chan(ch), .o_data(dat), .i_rsp_valid(rv),
      .i_rsp_data(rd));
   // value comparison, four-state exact
   task automatic cmp(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one command, answer checked
   task automatic q(input hpc_cmd_e o, input int c, input logic [31:0] d,
      input logic [31:0] e);
      host.send(o, 3'(c), d, src);
      cmp("answer", 1, host.got);
      cmp("source", src, rc);
      cmp("data", e, host.rsp);
   endtask
   function automatic logic [31:0] mapv();
      logic [31:0] m;
      m = '0;
      for (int n = 0; n < NCH; n++)
      begin
         m[2*n] = ehs[n];
         m[2*n+1] = epw[n];
         m[16+2*n] = ess[n];
      end
      return m;
   endfunction
   // enable model; even codes 0 to 8 switch on, odd codes switch off, code 10 loads the map
   task automatic apply(input int k, input int c, input logic [31:0] d);
      if (k == 10)
         for (int n = 0; n < NCH; n++)
         begin
            ehs[n] = d[2*n];
            epw[n] = d[2*n+1];
            ess[n] = d[16+2*n];
         end
      else
      begin
         if (k / 2 inside {0, 1, 2})
            ehs[c] = (k % 2 == 0);
         if (k / 2 inside {0, 1, 3})
            ess[c] = (k % 2 == 0);
         if (k / 2 inside {0, 4})
            epw[c] = (k % 2 == 0);
      end
   endtask
   task automatic pins();
      wt(2);
      cmp("hs_en", 32'(ehs), 32'(hse));
      cmp("ss_en", 32'(ess), 32'(sse));
      cmp("pwr_en", 32'(epw), 32'(pwe));
      q(CMD_GET_MAP, 0, 0, mapv());
   endtask
   // last low cycle of each power switch
   task automatic stag();
      for (int n = 0; n < 300; n++)
      begin
         for (int m = 0; m < NCH; m++)
            if (!pwe[m])
               t[m] = n + 1;
         wt(1);
      end
      for (int m = 2; m < NCH; m++)
         cmp("gap", 1, 32'(t[m] - t[m-1] inside {[20:22]}));
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard
   initial
   begin
      repeat (100000) @(posedge clk);
      n_fail++;
      end_sim();
   end
   initial
   begin
      {rstn, cable, v0, v1, src, lhs, lss, muv, mua} = '0;
      v0 = 1'b1;
      {ehs, ess, epw} = '1;
      k = $urandom(44);
      wt(4);
      cmp("ilim", ILIM_RESET_UA, ilim[0]);
      rstn <= 1'b1;
      wt(12);
      pins();
      q(CMD_GET_UP_SEL, 0, 0, UP_SEL_AUTO);
      $display("test reset done");
      for (int p = 0; p < 2; p++)
      begin
         src = p[0];
         cable <= p[0];
         wt(8);
         for (i = 0; i < 22; i++)
         begin
            k = i % 11;
            c = $urandom % 8;
            dr = $urandom;
            q(k == 10 ? CMD_SET_MAP : hpc_cmd_e'(k), c, dr, 0);
            apply(k, c, dr);
            pins();
         end
      end
      $display("test enables done");
      for (c = 0; c < NCH; c++)
      begin
         lim[c] = ($urandom % 4096) * 1000;
         md[c] = $urandom % 2;
         q(CMD_SET_LIMIT, c, lim[c], 0);
         q(CMD_GET_LIMIT, c, 0, lim[c]);
         q(CMD_SET_MODE, c, md[c], 0);
         q(CMD_GET_MODE, c, 0, md[c]);
      end
      for (k = 0; k < 3; k++)
      begin
         v0 <= (k != 1);
         wt(12);
         for (c = 0; c < NCH; c++)
         begin
            cmp("limit", lim[c], ilim[c]);
            cmp("adv", md[c] ? (k == 1 ? ADV_DEDICATED : ADV_CHARGING)
               : ADV_STANDARD, 32'(adv[c]));
         end
      end
      $display("test limits done");
      lhs <= 8'($urandom);
      lss <= 8'($urandom);
      for (c = 0; c < NCH; c++)
      begin
         muv[c] <= $urandom;
         mua[c] <= $urandom;
      end
      wt(8);
      for (c = 0; c < NCH; c++)
      begin
         q(CMD_GET_VOLT, c, 0, muv[c]);
         q(CMD_GET_CURR, c, 0, mua[c]);
         q(CMD_GET_SPEED, c, 0, lss[c] ? SPEED_SUPER : lhs[c] ? SPEED_HI
            : SPEED_NONE);
      end
      $display("test status done");
      for (k = 0; k < 4; k++)
      begin
         q(CMD_SET_UP_SEL, 0, codes[k], 0);
         q(CMD_SET_UP_SEL, 0, 7, 0);
         q(CMD_GET_UP_SEL, 0, 0, codes[k]);
         for (i = 0; i < 2; i++)
         begin
            v0 <= i[0];
            wt(8);
            cmp("up0", codes[k] == 0 || (codes[k] == 2 && i), u0);
            cmp("up1", codes[k] == 1 || (codes[k] == 2 && !i), u1);
         end
      end
      q(CMD_SET_UP_SEL, 0, UP_SEL_AUTO, 0);
      $display("test upstream done");
      for (k = 0; k < 4; k++)
      begin
         q(CMD_SET_DN_BOOST, 0, k, 0);
         q(CMD_SET_UP_BOOST, 0, 3 - k, 0);
         q(CMD_GET_DN_BOOST, 0, 0, k);
         q(CMD_GET_UP_BOOST, 0, 0, 3 - k);
         wt(2);
         cmp("boost_dn", k ? k - 1 : 0, bd);
         q(CMD_SAVE, 0, 0, 0);
         q(CMD_REBOOT, 0, 0, 0);
         wt(12);
         cmp("boost_dn", k, bd);
         cmp("boost_up", 3 - k, bu);
      end
      $display("test boost done");
      q(CMD_SET_MAP, 0, 32'hFFFF_FFFF, 0);
      q(CMD_SET_DELAY, 0, 2, 0);
      q(CMD_GET_DELAY, 0, 0, 2);
      q(CMD_REBOOT, 0, 0, 0);
      stag();
      v0 <= 1'b0;
      wt(8);
      v0 <= 1'b1;
      stag();
      $display("test stagger done");
      host.send(CMD_GET_MAP, 3'h0, 32'h0000_0000, 1'b0);
      cmp("refused", 0, host.got);
      cable <= 1'b0;
      wt(8);
      cmp("ctl_active", 0, ca);
      host.send(CMD_GET_MAP, 3'h0, 32'h0000_0000, 1'b1);
      cmp("refused", 0, host.got);
      $display("test control port done");
      rstn <= 1'b0;
      wt(4);
      cmp("boost_dn", 0, bd);
      cmp("ilim", ILIM_RESET_UA, ilim[5]);
      rstn <= 1'b1;
      src = 1'b0;
      {ehs, ess, epw} = '1;
      wt(12);
      pins();
      q(CMD_GET_DELAY, 0, 0, 0);
      q(CMD_GET_MODE, 4, 0, CHARGING_PORT_MODE);
      $display("test second reset done");
      end_sim();
   end
endmodule
`default_nettype wire
